// file: include/swe_pkg.sv
// Purpose : Shared types and constants for the sleep/wake event control block
// Assumes : Single always-on clock at 100 MHz, synchronous active-high reset
// Notes   : Pin inputs are raw pin levels; polarity is resolved inside the block
package swe_pkg;

  // ----------------------------------------------------------------
  // Power states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SWE_S0 = 2'b00,  // Working
    SWE_S3 = 2'b01,  // Suspend to RAM
    SWE_S4 = 2'b10,  // Suspend to disk
    SWE_S5 = 2'b11   // Soft-off
  } swe_state_t;

  // ----------------------------------------------------------------
  // Wake source bit positions
  // ----------------------------------------------------------------
  localparam int SWE_SRC_W     = 8;
  localparam int SWE_BIT_PBTN  = 0;
  localparam int SWE_BIT_SMBA  = 1;
  localparam int SWE_BIT_PEWK  = 2;
  localparam int SWE_BIT_WDPB  = 3;
  localparam int SWE_BIT_WAKE  = 4;
  localparam int SWE_BIT_LAN   = 5;
  localparam int SWE_BIT_PME   = 6;
  localparam int SWE_BIT_USB   = 7;
  localparam int SWE_BIT_RTC   = 8;
  localparam int SWE_CAUSE_W   = 9;

  // Active-low pins: power button, SMBus alert, link wake, general wake, PME
  localparam logic [SWE_CAUSE_W-1:0] SWE_ACT_LOW_MASK = 9'h057;

  // Reset values
  localparam logic [SWE_CAUSE_W-1:0] SWE_CAUSE_RST = 9'h000;
  localparam logic [1:0]             SWE_SYNC_RST  = 2'h0;

  // Pull-down strap: 1 = tied low, 0 = left open
  localparam logic SWE_STRAP_DEF = 1'b1;

  // Enable settings
  typedef struct packed {
    logic lan_wol_en;   // LAN wake configured in driver
    logic pme_dev_en;   // Per-device wake capability
    logic pme_resume_en;// Resume-on-event setting
    logic usb_wake_en;  // USB device wakeup setting
    logic rtc_alarm_en; // Resume-on-alarm enabled and configured
  } swe_cfg_t;

  // Block state, apart from the strap flops
  typedef struct packed {
    logic [SWE_CAUSE_W-1:0] sync1;
    logic [SWE_CAUSE_W-1:0] sync2;
    logic                   wake_req;
    logic [SWE_CAUSE_W-1:0] cause;
  } swe_regs_t;

endpackage : swe_pkg

// file: rtl/swe_wake_ctrl.sv
// Purpose : Qualifies wake sources against the current sleep state and enables
// Assumes : sleep_state comes from the power sequencer on clk; pins are async
// Notes   : Request holds until wake_ack; sources are ignored in working state
`timescale 1ns/1ps
module swe_wake_ctrl #(
  parameter logic STRAP_TIED = swe_pkg::SWE_STRAP_DEF
) (
  // Clock and reset
  input  wire logic                             clk,
  input  wire logic                             srst,
  // Power sequencer
  input  wire swe_pkg::swe_state_t              sleep_state,
  input  wire logic                             wake_ack,
  output logic                                  wake_req,
  output logic [swe_pkg::SWE_CAUSE_W-1:0]       wake_cause,
  // Enable settings
  input  wire swe_pkg::swe_cfg_t                cfg,
  // Raw pins (active-low ones carry _n)
  input  wire logic                             pwr_btn_n,
  input  wire logic                             smb_alert_n,
  input  wire logic                             pcie_wake_n,
  input  wire logic                             wdt_pwrbtn,
  input  wire logic                             gen_wake_n,
  input  wire logic                             lan_wake,
  input  wire logic                             pme_n,
  input  wire logic                             usb_wake,
  input  wire logic                             rtc_alarm,
  // Pull-down strap pin
  output logic                                  pull_down_strap_o,
  output logic                                  pull_down_strap_oe
);
  import swe_pkg::*;

  swe_regs_t              r_reg;
  swe_regs_t              r_next;
  logic [SWE_CAUSE_W-1:0] pins;
  logic [SWE_CAUSE_W-1:0] act;
  logic [SWE_CAUSE_W-1:0] qual;
  logic                   strap_oe_reg;
  logic                   strap_o_reg;

  // ----------------------------------------------------------------
  // Pin gathering and polarity
  // ----------------------------------------------------------------
  // Map pins into cause bit order
  always_comb begin
    pins               = '0;
    pins[SWE_BIT_PBTN] = pwr_btn_n;
    pins[SWE_BIT_SMBA] = smb_alert_n;
    pins[SWE_BIT_PEWK] = pcie_wake_n;
    pins[SWE_BIT_WDPB] = wdt_pwrbtn;
    pins[SWE_BIT_WAKE] = gen_wake_n;
    pins[SWE_BIT_LAN]  = lan_wake;
    pins[SWE_BIT_PME]  = pme_n;
    pins[SWE_BIT_USB]  = usb_wake;
    pins[SWE_BIT_RTC]  = rtc_alarm;
  end

  // Invert only after the second synchroniser stage
  assign act = r_reg.sync2 ^ SWE_ACT_LOW_MASK;

  // ----------------------------------------------------------------
  // Qualification per source
  // ----------------------------------------------------------------
  // Each sleep state decoded separately so S3/S4/S5 gate differently
  always_comb begin
    logic in_s3;
    logic in_s4;
    logic in_s5;
    logic asleep;
    in_s3  = (sleep_state == SWE_S3);
    in_s4  = (sleep_state == SWE_S4);
    in_s5  = (sleep_state == SWE_S5);
    asleep = in_s3 | in_s4 | in_s5;
    qual               = '0;
    qual[SWE_BIT_PBTN] = asleep & act[SWE_BIT_PBTN];
    qual[SWE_BIT_SMBA] = asleep & act[SWE_BIT_SMBA];
    qual[SWE_BIT_PEWK] = asleep & act[SWE_BIT_PEWK];
    qual[SWE_BIT_WDPB] = asleep & act[SWE_BIT_WDPB];
    qual[SWE_BIT_WAKE] = in_s3 & act[SWE_BIT_WAKE];
    qual[SWE_BIT_LAN]  = asleep & cfg.lan_wol_en & act[SWE_BIT_LAN];
    qual[SWE_BIT_PME]  = asleep & (cfg.pme_dev_en | cfg.pme_resume_en) & act[SWE_BIT_PME];
    // Standby power to USB in S3 is the board's job; we only gate the event
    qual[SWE_BIT_USB]  = (in_s3 | in_s4) & cfg.usb_wake_en & act[SWE_BIT_USB];
    qual[SWE_BIT_RTC]  = in_s5 & cfg.rtc_alarm_en & act[SWE_BIT_RTC];
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // New causes win over the acknowledge so no event is lost in that cycle
  // A held source keeps re-requesting, so ack only clears what has gone quiet
  always_comb begin
    r_next       = r_reg;
    r_next.sync1 = pins;
    r_next.sync2 = r_reg.sync1;
    if (wake_ack) begin
      r_next.cause    = qual;
      r_next.wake_req = |qual;
    end else begin
      r_next.cause    = r_reg.cause | qual;
      r_next.wake_req = r_reg.wake_req | (|qual);
    end
  end

  // State register; synchronisers reset to idle pin levels
  always_ff @(posedge clk) begin
    if (srst) begin
      r_reg.sync1    <= SWE_ACT_LOW_MASK;
      r_reg.sync2    <= SWE_ACT_LOW_MASK;
      r_reg.wake_req <= 1'b0;
      r_reg.cause    <= SWE_CAUSE_RST;
      strap_oe_reg   <= 1'b0;
      strap_o_reg    <= 1'b0;
    end else begin
      r_reg        <= r_next;
      strap_oe_reg <= STRAP_TIED;
      strap_o_reg  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wake_req           = r_reg.wake_req;
  assign wake_cause         = r_reg.cause;
  // Strap never drives high: either pulled to ground or released
  // Registered so the pin output comes straight from a flop like the others
  assign pull_down_strap_o  = strap_o_reg;
  assign pull_down_strap_oe = strap_oe_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Qualification: each source against sleep state and enables
  AST_IGNORE_S0: assert property (@(posedge clk) disable iff (srst)
    (sleep_state == SWE_S0) |-> (qual == '0))
    else $error("wake qualified in working state");
  AST_UNCOND: assert property (@(posedge clk) disable iff (srst)
    (sleep_state != SWE_S0) |-> (qual[SWE_BIT_WDPB:SWE_BIT_PBTN] == act[SWE_BIT_WDPB:SWE_BIT_PBTN]))
    else $error("unconditional source not qualified");
  AST_GEN_S3: assert property (@(posedge clk) disable iff (srst)
    (sleep_state == SWE_S3 && act[SWE_BIT_WAKE]) |-> qual[SWE_BIT_WAKE])
    else $error("general wake refused in S3");
  AST_LAN_POS: assert property (@(posedge clk) disable iff (srst)
    (sleep_state != SWE_S0 && cfg.lan_wol_en && act[SWE_BIT_LAN]) |-> qual[SWE_BIT_LAN])
    else $error("enabled LAN wake refused");
  AST_PME_POS: assert property (@(posedge clk) disable iff (srst)
    (sleep_state != SWE_S0 && (cfg.pme_dev_en || cfg.pme_resume_en) && act[SWE_BIT_PME]) |-> qual[SWE_BIT_PME])
    else $error("enabled PME wake refused");
  AST_USB_POS: assert property (@(posedge clk) disable iff (srst)
    ((sleep_state == SWE_S3 || sleep_state == SWE_S4) && cfg.usb_wake_en && act[SWE_BIT_USB]) |-> qual[SWE_BIT_USB])
    else $error("enabled USB wake refused");
  AST_RTC_POS: assert property (@(posedge clk) disable iff (srst)
    (sleep_state == SWE_S5 && cfg.rtc_alarm_en && act[SWE_BIT_RTC]) |-> qual[SWE_BIT_RTC])
    else $error("enabled RTC wake refused in S5");
  AST_PBTN_WAKES: assert property (@(posedge clk) disable iff (srst)
    (sleep_state != SWE_S0 && act[SWE_BIT_PBTN]) |=> (wake_req && wake_cause[SWE_BIT_PBTN]))
    else $error("power button did not raise wake");
  AST_WAKE_S3_ONLY: assert property (@(posedge clk) disable iff (srst)
    qual[SWE_BIT_WAKE] |-> (sleep_state == SWE_S3))
    else $error("general wake used outside S3");
  AST_LAN_EN: assert property (@(posedge clk) disable iff (srst)
    qual[SWE_BIT_LAN] |-> cfg.lan_wol_en)
    else $error("LAN wake without enable");
  AST_PME_EN: assert property (@(posedge clk) disable iff (srst)
    qual[SWE_BIT_PME] |-> (cfg.pme_dev_en || cfg.pme_resume_en))
    else $error("PME wake without enable");
  AST_USB_GATE: assert property (@(posedge clk) disable iff (srst)
    qual[SWE_BIT_USB] |-> (cfg.usb_wake_en && (sleep_state == SWE_S3 || sleep_state == SWE_S4)))
    else $error("USB wake not qualified");
  AST_RTC_S5: assert property (@(posedge clk) disable iff (srst)
    qual[SWE_BIT_RTC] |-> (cfg.rtc_alarm_en && sleep_state == SWE_S5))
    else $error("RTC wake not qualified");

  // ----------------------------------------------------------------
  // Latch, handshake, polarity and strap checks
  // ----------------------------------------------------------------
  AST_HOLD: assert property (@(posedge clk) disable iff (srst)
    (wake_req && !wake_ack) |=> wake_req)
    else $error("wake request dropped before ack");
  AST_CAUSE_STICKY: assert property (@(posedge clk) disable iff (srst)
    !wake_ack |=> ((wake_cause & $past(wake_cause)) == $past(wake_cause)))
    else $error("cause bit lost without ack");
  AST_ACK_CLEAR: assert property (@(posedge clk) disable iff (srst)
    (wake_ack && qual == '0) |=> (!wake_req && wake_cause == '0))
    else $error("ack did not clear quiet causes");
  AST_SET_WINS: assert property (@(posedge clk) disable iff (srst)
    (wake_ack && qual != '0) |=> (wake_req && wake_cause == $past(qual)))
    else $error("active cause lost on ack edge");
  // Pin reaches qual two edges after it is sampled; skip edges fed by reset values
  AST_POLARITY: assert property (@(posedge clk) disable iff (srst)
    (!$past(srst, 1) && !$past(srst, 2) && !$past(pwr_btn_n, 2) && sleep_state != SWE_S0) |-> qual[SWE_BIT_PBTN])
    else $error("active-low pin not honoured");
  AST_POLARITY_HIGH: assert property (@(posedge clk) disable iff (srst)
    (!$past(srst, 1) && !$past(srst, 2) && $past(wdt_pwrbtn, 2) && sleep_state != SWE_S0) |-> qual[SWE_BIT_WDPB])
    else $error("active-high pin not honoured");
  AST_STRAP: assert property (@(posedge clk) disable iff (srst)
    !pull_down_strap_o)
    else $error("strap driven high");
  AST_STRAP_OE: assert property (@(posedge clk) disable iff (srst)
    !$past(srst) |-> (pull_down_strap_oe == STRAP_TIED))
    else $error("strap enable differs from tie setting");

  // Main scenarios: S3 general wake, S5 alarm, USB, ack clear, relatch on ack
  COV_S3_WAKE: cover property (@(posedge clk) disable iff (srst) qual[SWE_BIT_WAKE]);
  COV_S5_RTC:  cover property (@(posedge clk) disable iff (srst) qual[SWE_BIT_RTC]);
  COV_USB:     cover property (@(posedge clk) disable iff (srst) qual[SWE_BIT_USB]);
  COV_ACK:     cover property (@(posedge clk) disable iff (srst) wake_req ##1 wake_ack ##1 !wake_req);
  COV_RELATCH: cover property (@(posedge clk) disable iff (srst) wake_ack && (qual != '0));

endmodule : swe_wake_ctrl

// file: tb/swe_board_model.sv
// Purpose : Carrier-side wake sources, driving the raw pins from asserted events
// Assumes : act bit positions follow the wake_cause bit order
// Notes   : Pins are levels; the bench changes act just after a rising edge
`timescale 1ns/1ps
module swe_board_model (
  // Asserted sources
  input  wire logic [8:0] act,
  // Raw pins
  output logic            pwr_btn_n,
  output logic            smb_alert_n,
  output logic            pcie_wake_n,
  output logic            wdt_pwrbtn,
  output logic            gen_wake_n,
  output logic            lan_wake,
  output logic            pme_n,
  output logic            usb_wake,
  output logic            rtc_alarm
);
  // Hash-named pins sit low when asserted, the rest high
  assign pwr_btn_n   = ~act[0];
  assign smb_alert_n = ~act[1];
  assign pcie_wake_n = ~act[2];
  assign wdt_pwrbtn  = act[3];
  assign gen_wake_n  = ~act[4];
  assign lan_wake    = act[5];
  assign pme_n       = ~act[6];
  // USB stays on standby supply, so its wake line is alive in sleep
  assign usb_wake    = act[7];
  assign rtc_alarm   = act[8];
endmodule : swe_board_model

// file: tb/tb.sv
// Purpose : Self-checking bench for the wake source qualifier
// Assumes : Default strap parameter (tied to ground)
// Notes   : Each source is held, released, then acknowledged
`timescale 1ns/1ps
module tb;
  import swe_pkg::*;
  logic clk = 1'b0, srst = 1'b1, wake_ack = 1'b0, wake_req, strap_o, strap_oe;
  logic p0, p1, p2, p3, p4, p5, p6, p7, p8;
  logic [8:0] act = 9'h000, wake_cause;
  swe_state_t sleep_state = SWE_S0;
  swe_cfg_t   cfg = 5'h00;
  int error_cnt = 0, checked = 0;
  swe_board_model board (.act(act), .pwr_btn_n(p0), .smb_alert_n(p1), .pcie_wake_n(p2), .wdt_pwrbtn(p3),
    .gen_wake_n(p4), .lan_wake(p5), .pme_n(p6), .usb_wake(p7), .rtc_alarm(p8));
  swe_wake_ctrl dut (.clk(clk), .srst(srst), .sleep_state(sleep_state), .wake_ack(wake_ack),
    .wake_req(wake_req), .wake_cause(wake_cause), .cfg(cfg), .pwr_btn_n(p0), .smb_alert_n(p1),
    .pcie_wake_n(p2), .wdt_pwrbtn(p3), .gen_wake_n(p4), .lan_wake(p5), .pme_n(p6), .usb_wake(p7),
    .rtc_alarm(p8), .pull_down_strap_o(strap_o), .pull_down_strap_oe(strap_oe));
  // 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic cmp(input string what, input logic [8:0] exp, input logic [8:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic report_and_stop;
    if (error_cnt == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  // Hold a source past the sync stages, release it, check the latch, then ack
  task automatic fire(input swe_state_t st, input swe_cfg_t c, input int b, input logic ok);
    @(posedge clk);
    sleep_state <= st;
    cfg <= c;
    act <= 9'h001 << b;
    repeat (4) @(posedge clk);
    act <= 9'h000;
    repeat (4) @(posedge clk);
    #1 cmp("wake_cause", ok ? 9'h001 << b : 9'h000, wake_cause);
    cmp("wake_req", {8'h00, ok}, {8'h00, wake_req});
    @(posedge clk);
    wake_ack <= 1'b1;
    @(posedge clk);
    wake_ack <= 1'b0;
    @(posedge clk);
    #1 cmp("cause_after_ack", 9'h000, wake_cause);
    cmp("req_after_ack", 9'h000, {8'h00, wake_req});
  endtask : fire
  // Ack while the source is still held must keep the cause latched
  task automatic t_ack_hold;
    @(posedge clk);
    sleep_state <= SWE_S3;
    cfg <= 5'h00;
    act <= 9'h001;
    repeat (4) @(posedge clk);
    wake_ack <= 1'b1;
    @(posedge clk);
    wake_ack <= 1'b0;
    act <= 9'h000;
    #1 cmp("cause_relatch", 9'h001, wake_cause);
    cmp("req_relatch", 9'h001, {8'h00, wake_req});
    repeat (3) @(posedge clk);
    wake_ack <= 1'b1;
    @(posedge clk);
    wake_ack <= 1'b0;
    @(posedge clk);
    #1 cmp("cause_cleared", 9'h000, wake_cause);
    cmp("req_cleared", 9'h000, {8'h00, wake_req});
  endtask : t_ack_hold
  // Reset in mid-run drops a pending request and releases the strap
  task automatic t_mid_reset;
    @(posedge clk);
    sleep_state <= SWE_S5;
    act <= 9'h001;
    repeat (4) @(posedge clk);
    srst <= 1'b1;
    act <= 9'h000;
    repeat (2) @(posedge clk);
    #1 cmp("cause_in_reset", 9'h000, wake_cause);
    cmp("strap_oe_mid_reset", 9'h000, {8'h00, strap_oe});
    @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    #1 cmp("req_after_reset", 9'h000, {8'h00, wake_req});
    cmp("strap_oe_after_reset", 9'h001, {8'h00, strap_oe});
  endtask : t_mid_reset
  task automatic t_uncond;
    for (int s = 1; s < 4; s++) begin
      for (int b = 0; b < 4; b++) fire(swe_state_t'(s), 5'h00, b, 1'b1);
    end
  endtask : t_uncond
  task automatic t_gen;
    fire(SWE_S3, 5'h00, 4, 1'b1);
    fire(SWE_S4, 5'h1f, 4, 1'b0);
    fire(SWE_S5, 5'h1f, 4, 1'b0);
  endtask : t_gen
  task automatic t_lan;
    fire(SWE_S4, 5'h0f, 5, 1'b0);
    fire(SWE_S4, 5'h10, 5, 1'b1);
  endtask : t_lan
  task automatic t_pme;
    fire(SWE_S3, 5'h13, 6, 1'b0);
    fire(SWE_S3, 5'h08, 6, 1'b1);
    fire(SWE_S5, 5'h04, 6, 1'b1);
  endtask : t_pme
  task automatic t_usb;
    fire(SWE_S3, 5'h02, 7, 1'b1);
    fire(SWE_S4, 5'h02, 7, 1'b1);
    fire(SWE_S5, 5'h1f, 7, 1'b0);
    fire(SWE_S3, 5'h1d, 7, 1'b0);
  endtask : t_usb
  task automatic t_rtc;
    fire(SWE_S5, 5'h01, 8, 1'b1);
    fire(SWE_S3, 5'h1f, 8, 1'b0);
    fire(SWE_S5, 5'h1e, 8, 1'b0);
  endtask : t_rtc
  task automatic t_working;
    for (int b = 0; b < 9; b++) fire(SWE_S0, 5'h1f, b, 1'b0);
  endtask : t_working
  // Strap is held ground-tied after reset
  task automatic t_strap;
    cmp("strap_o", 9'h000, {8'h00, strap_o});
    cmp("strap_oe", 9'h001, {8'h00, strap_oe});
  endtask : t_strap
  initial begin
    repeat (20) @(posedge clk);
    #1 cmp("strap_oe_in_reset", 9'h000, {8'h00, strap_oe});
    @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    #1 t_strap();
    t_uncond();
    t_gen();
    t_lan();
    t_pme();
    t_usb();
    t_rtc();
    t_working();
    t_ack_hold();
    t_mid_reset();
    report_and_stop();
  end
  // Hang guard: the tests take well under 1000 cycles
  initial begin
    #100000;
    error_cnt++;
    report_and_stop();
  end
endmodule : tb
